// [rcc_receive_config.sv]
// receive configuration register, receive event register and status queue view
// assumes frame status inputs come from the receive engine on clk_sys
`timescale 1ns/1ps
`default_nettype none
module rcc_receive_config (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        frame_done,
  input  wire logic        frame_good,
  input  wire logic        frame_bad_fcs,
  input  wire logic        frame_short,
  input  wire logic        frame_long,
  input  wire logic        frame_dribble,
  input  wire logic        frame_hashed,
  input  wire logic        frame_ia_hash,
  input  wire logic        frame_indiv,
  input  wire logic        frame_bcast,
  input  wire logic        frame_dest_pass,
  input  wire logic        frame_follow_on,
  input  wire logic        buffer_full,
  output logic             skip_frame,
  output logic             dma_path,
  output logic             back_to_back_transfer_mode,
  output logic             keep_fcs_in_buffer,
  output logic             irq
);

  rcc_pkg::rcc_state_t s_r;
  rcc_pkg::rcc_state_t s_nxt;
  logic                path_w;
  logic                hit_w;

  // read value of an addressed register
  function automatic logic [15:0] rcc_read(input logic [11:0] a,
                                           input rcc_pkg::rcc_state_t s);
    logic [15:0] v;
    v = rcc_pkg::RCC_ZERO16;
    case (a)
      rcc_pkg::RCC_OFS_CFG: v = {s.cfg[15:6], rcc_pkg::RCC_NUM_CFG};
      rcc_pkg::RCC_OFS_EVT: v = s.evt;
      rcc_pkg::RCC_OFS_ISQ: v = s.pend ? s.evt : rcc_pkg::RCC_ZERO16;
      default:              v = rcc_pkg::RCC_ZERO16;
    endcase
    return v;
  endfunction

  // frame path and interrupt qualification
  assign path_w = s_r.cfg[rcc_pkg::RCC_B_DMAALL] |
                  (s_r.cfg[rcc_pkg::RCC_B_DMAAUT] & buffer_full);
  assign hit_w  = (frame_good & s_r.cfg[rcc_pkg::RCC_B_GOODIE] & ~path_w) |
                  (frame_bad_fcs & s_r.cfg[rcc_pkg::RCC_B_FCSIE]) |
                  (frame_short & s_r.cfg[rcc_pkg::RCC_B_SHRTIE]) |
                  (frame_long & s_r.cfg[rcc_pkg::RCC_B_LONGIE]);

  // next state
  always_comb begin
    s_nxt      = s_r;
    // discard pulse defaults low so each write acts only once
    s_nxt.skip = 1'b0;
    if (reg_wr && reg_addr == rcc_pkg::RCC_OFS_CFG) begin
      s_nxt.cfg  = reg_wdata & rcc_pkg::RCC_CFG_WMASK;
      s_nxt.skip = reg_wdata[rcc_pkg::RCC_B_SKIP];
    end
    if (reg_rd) begin
      s_nxt.rdata = rcc_read(reg_addr, s_r);
    end
    // reading the event or queue consumes the pending event
    if (reg_rd && (reg_addr == rcc_pkg::RCC_OFS_ISQ || reg_addr == rcc_pkg::RCC_OFS_EVT)) begin
      s_nxt.pend = 1'b0;
      s_nxt.evt  = rcc_pkg::RCC_EVT_RST;
    end
    // a new frame wins over a same-cycle read clear
    if (frame_done) begin
      s_nxt.dma_path = path_w;
      s_nxt.b2b      = s_r.cfg[rcc_pkg::RCC_B_STREAM] & frame_dest_pass & frame_follow_on;
      // event header keeps its register number, status bits follow the frame
      s_nxt.evt      = rcc_pkg::RCC_EVT_RST;
      s_nxt.evt[rcc_pkg::RCC_E_IAHASH] = frame_ia_hash;
      s_nxt.evt[rcc_pkg::RCC_E_DRIB]   = frame_dribble;
      s_nxt.evt[rcc_pkg::RCC_E_GOOD]   = frame_good;
      s_nxt.evt[rcc_pkg::RCC_E_HASHED] = frame_hashed;
      s_nxt.evt[rcc_pkg::RCC_E_INDIV]  = frame_indiv;
      s_nxt.evt[rcc_pkg::RCC_E_BCAST]  = frame_bcast;
      s_nxt.evt[rcc_pkg::RCC_E_FCS]    = frame_bad_fcs;
      s_nxt.evt[rcc_pkg::RCC_E_SHORT]  = frame_short;
      s_nxt.evt[rcc_pkg::RCC_E_LONG]   = frame_long;
      if (hit_w) begin
        s_nxt.pend = 1'b1;
      end
    end
    s_nxt.irq = s_nxt.pend;
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.cfg      <= rcc_pkg::RCC_CFG_RST;
      s_r.evt      <= rcc_pkg::RCC_EVT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata                  = s_r.rdata;
  assign skip_frame                 = s_r.skip;
  assign dma_path                   = s_r.dma_path;
  assign back_to_back_transfer_mode = s_r.b2b;
  assign keep_fcs_in_buffer         = s_r.cfg[rcc_pkg::RCC_B_KEEPFC];
  assign irq                        = s_r.irq;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // configuration read carries its own register number
  cfg_ident_a: assert property (reg_rd && reg_addr == rcc_pkg::RCC_OFS_CFG
    |=> reg_rdata[5:0] == 6'h03) else $error("configuration id bits wrong");
  // skip bit is never stored, so it reads back low
  cfg_bit6_a: assert property (reg_rd && reg_addr == rcc_pkg::RCC_OFS_CFG
    |=> !reg_rdata[6]) else $error("skip bit read back high");
  // unmapped offsets read as zero
  other_zero_a: assert property (reg_rd && reg_addr != rcc_pkg::RCC_OFS_CFG
    && reg_addr != rcc_pkg::RCC_OFS_EVT && reg_addr != rcc_pkg::RCC_OFS_ISQ
    |=> reg_rdata == 16'h0000) else $error("unmapped offset read nonzero");
  // read data holds between reads
  rdata_hold_a: assert property (!reg_rd
    |=> $stable(reg_rdata)) else $error("read data changed without a read");
  // skip write gives a discard pulse next cycle
  skip_pulse_a: assert property (reg_wr && reg_addr == rcc_pkg::RCC_OFS_CFG && reg_wdata[6]
    |=> skip_frame) else $error("skip write gave no discard");
  // discard only follows a skip write
  skip_once_a: assert property (skip_frame
    |-> $past(reg_wr && reg_addr == rcc_pkg::RCC_OFS_CFG && reg_wdata[6]))
    else $error("discard without a skip write");
  // a lone discard lasts one cycle
  skip_single_a: assert property (skip_frame && !(reg_wr && reg_addr == rcc_pkg::RCC_OFS_CFG && reg_wdata[6])
    |=> !skip_frame) else $error("discard pulse held too long");
  // back-to-back mode follows the enable and frame qualifiers
  b2b_mode_a: assert property (frame_done
    |=> back_to_back_transfer_mode == $past(s_r.cfg[7] & frame_dest_pass & frame_follow_on))
    else $error("back-to-back mode wrong");
  // no back-to-back mode with the enable clear
  b2b_off_a: assert property (frame_done && !s_r.cfg[7]
    |=> !back_to_back_transfer_mode) else $error("back-to-back mode without enable");
  // good frame on the buffer path interrupts
  good_irq_a: assert property (frame_done && frame_good && s_r.cfg[8] && !path_w
    |=> irq) else $error("good frame gave no interrupt");
  // good frame on the DMA path stays quiet
  dma_quiet_a: assert property (frame_done && path_w && !frame_bad_fcs && !frame_short
    && !frame_long && !s_r.pend |=> !irq) else $error("interrupt on a DMA frame");
  // DMA always takes every frame
  dma_sel_a: assert property (frame_done && s_r.cfg[9] |=> dma_path)
    else $error("DMA always not honoured");
  // auto switch follows the buffer state
  auto_dma_a: assert property (frame_done && !s_r.cfg[9] && s_r.cfg[10]
    |=> dma_path == $past(buffer_full)) else $error("auto switch path wrong");
  // both DMA settings clear keeps frames in the buffer
  dma_off_a: assert property (frame_done && !s_r.cfg[9] && !s_r.cfg[10]
    |=> !dma_path) else $error("DMA used with both settings clear");
  // bad FCS interrupt when enabled
  fcs_irq_a: assert property (frame_done && frame_bad_fcs && s_r.cfg[12]
    |=> irq) else $error("bad FCS gave no interrupt");
  // short frame interrupt when enabled
  short_irq_a: assert property (frame_done && frame_short && s_r.cfg[13]
    |=> irq) else $error("short frame gave no interrupt");
  // long frame interrupt when enabled
  long_irq_a: assert property (frame_done && frame_long && s_r.cfg[14]
    |=> irq) else $error("long frame gave no interrupt");
  // no enable, no interrupt
  err_gate_a: assert property (frame_done && !s_r.pend && !(frame_bad_fcs && s_r.cfg[12])
    && !(frame_short && s_r.cfg[13]) && !(frame_long && s_r.cfg[14])
    && !(frame_good && s_r.cfg[8]) |=> !irq) else $error("interrupt without enable");
  // good-frame enable lands in bit 8
  good_en_a: assert property (reg_wr && reg_addr == rcc_pkg::RCC_OFS_CFG
    |=> s_r.cfg[8] == $past(reg_wdata[8])) else $error("good-frame enable not stored");
  // buffer option follows bit 11
  keep_fcs_a: assert property (reg_wr && reg_addr == rcc_pkg::RCC_OFS_CFG
    |=> keep_fcs_in_buffer == $past(reg_wdata[11])) else $error("buffer option not stored");
  // event header and good flag after a frame
  evt_hdr_a: assert property (frame_done |=> s_r.evt[5:0] == 6'h04
    && s_r.evt[8] == $past(frame_good)) else $error("event register wrong");
  // queue read shows the event and drops the interrupt
  isq_view_a: assert property (irq && reg_rd && reg_addr == rcc_pkg::RCC_OFS_ISQ && !frame_done
    |=> reg_rdata[5:0] == 6'h04 && !irq) else $error("queue view wrong");
  // empty queue reads as zero
  isq_empty_a: assert property (reg_rd && reg_addr == rcc_pkg::RCC_OFS_ISQ && !s_r.pend
    |=> reg_rdata == 16'h0000) else $error("empty queue read nonzero");
  // queue read returns the event register to its header
  evt_reset_a: assert property (reg_rd && reg_addr == rcc_pkg::RCC_OFS_ISQ && !frame_done
    |=> s_r.evt == 16'h0004) else $error("event register not cleared");
  // direct event read also drops the interrupt
  evt_clear_a: assert property (reg_rd && reg_addr == rcc_pkg::RCC_OFS_EVT && !frame_done
    |=> !irq) else $error("event read left interrupt high");
  // interrupt holds until software reads
  irq_hold_a: assert property (irq && !reg_rd
    |=> irq) else $error("interrupt dropped without a read");

  // main scenarios
  good_cov: cover property (frame_done && frame_good ##1 irq);
  skip_cov: cover property (skip_frame);
  b2b_cov:  cover property (frame_done ##1 back_to_back_transfer_mode);
  clr_cov:  cover property (irq && reg_rd && reg_addr == rcc_pkg::RCC_OFS_ISQ ##2 !irq);
  dma_cov:  cover property (frame_done ##1 dma_path);

endmodule
`default_nettype wire

// [rcc_pkg.sv]
// receive configuration control: constants, field layout and state type
// assumes a 12-bit register offset and 16-bit register data
package rcc_pkg;
  // register offsets
  localparam logic [11:0] RCC_OFS_ISQ = 12'h120;
  localparam logic [11:0] RCC_OFS_CFG = 12'h102;
  localparam logic [11:0] RCC_OFS_EVT = 12'h124;
  // fixed register numbers in the low six bits
  localparam logic [5:0]  RCC_NUM_CFG = 6'h03;
  localparam logic [5:0]  RCC_NUM_EVT = 6'h04;
  // configuration bit positions
  localparam int RCC_B_STREAM = 7;
  localparam int RCC_B_SKIP   = 6;
  localparam int RCC_B_GOODIE = 8;
  localparam int RCC_B_DMAALL = 9;
  localparam int RCC_B_DMAAUT = 10;
  localparam int RCC_B_KEEPFC = 11;
  localparam int RCC_B_FCSIE  = 12;
  localparam int RCC_B_SHRTIE = 13;
  localparam int RCC_B_LONGIE = 14;
  // writable configuration bits (7, 8..E)
  localparam logic [15:0] RCC_CFG_WMASK = 16'h7F80;
  localparam logic [15:0] RCC_CFG_RST   = 16'h0000;
  // event register bit positions
  localparam int RCC_E_IAHASH = 6;
  localparam int RCC_E_DRIB   = 7;
  localparam int RCC_E_GOOD   = 8;
  localparam int RCC_E_HASHED = 9;
  localparam int RCC_E_INDIV  = 10;
  localparam int RCC_E_BCAST  = 11;
  localparam int RCC_E_FCS    = 12;
  localparam int RCC_E_SHORT  = 13;
  localparam int RCC_E_LONG   = 14;
  localparam logic [15:0] RCC_EVT_RST = {10'h000, RCC_NUM_EVT};
  localparam logic [15:0] RCC_ZERO16  = 16'h0000;

  // whole block state
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] evt;
    logic        pend;
    logic        irq;
    logic        skip;
    logic        dma_path;
    logic        b2b;
    logic [15:0] rdata;
  } rcc_state_t;
endpackage

// [tb_top.sv]
// self-checking bench for the receive configuration control block
// assumes clk_sys at 40 MHz and the register and frame strobes described in the notes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys, rst_n, reg_wr, reg_rd, frame_done;
  logic [11:0] reg_addr, fl;
  logic [15:0] reg_wdata, reg_rdata, seed, w;
  logic        skip_frame, dma_path, b2b, keep_fcs, irq, dma, en;
  int          n_mismatch, check_count, i;
  rcc_receive_config dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .frame_done(frame_done), .frame_good(fl[0]), .frame_bad_fcs(fl[1]),
    .frame_short(fl[2]), .frame_long(fl[3]), .frame_dribble(fl[4]), .frame_hashed(fl[5]),
    .frame_ia_hash(fl[6]), .frame_indiv(fl[7]), .frame_bcast(fl[8]),
    .frame_dest_pass(fl[9]), .frame_follow_on(fl[10]), .buffer_full(fl[11]),
    .skip_frame(skip_frame), .dma_path(dma_path), .back_to_back_transfer_mode(b2b),
    .keep_fcs_in_buffer(keep_fcs), .irq(irq));
  // clock generator
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // random source
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // expected frame path
  function automatic logic exp_dma(input logic [15:0] c, input logic bf);
    return c[9] | (c[10] & bf);
  endfunction
  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    cyc();
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    reg_addr = a; reg_rd = 1'b1;
    cyc();
    reg_rd = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 12'h000; reg_wdata = 16'h0000;
    frame_done = 1'b0; fl = 12'h000; seed = 16'h001E; n_mismatch = 0; check_count = 0;
    repeat (10) cyc();
    rst_n = 1'b1;
    rd(rcc_pkg::RCC_OFS_CFG); check(reg_rdata, 16'h0003);
    rd(rcc_pkg::RCC_OFS_EVT); check(reg_rdata, 16'h0004);
    rd(12'h200); check(reg_rdata, 16'h0000);
    $display("reset test done");
    for (i = 0; i < 40; i++) begin
      seed = lfsr_next(seed);
      w = (i == 0) ? 16'hFFFF : seed;
      if (w[9]) w[6] = 1'b0;
      if (w[7] && !(w[9] | w[10])) w[10] = 1'b1;
      wr(rcc_pkg::RCC_OFS_CFG, w);
      check({15'h0000, skip_frame}, {15'h0000, w[6]});
      cyc(); check({15'h0000, skip_frame}, 16'h0000);
      rd(rcc_pkg::RCC_OFS_CFG); check(reg_rdata, (w & 16'h7F80) | 16'h0003);
      check({15'h0000, keep_fcs}, {15'h0000, w[11]});
      seed = lfsr_next(seed); fl = seed[11:0];
      frame_done = 1'b1;
      cyc();
      frame_done = 1'b0;
      dma = exp_dma(w, fl[11]);
      en = (fl[0] & w[8] & !dma) | (fl[1] & w[12]) | (fl[2] & w[13]) | (fl[3] & w[14]);
      check({15'h0000, dma_path}, {15'h0000, dma});
      check({15'h0000, irq}, {15'h0000, en});
      if (!w[7]) check({15'h0000, b2b}, 16'h0000);
      else if (fl[9] & fl[10]) check({15'h0000, b2b}, 16'h0001);
      else check({15'h0000, b2b}, 16'h0000);
      rd(rcc_pkg::RCC_OFS_ISQ);
      if (en) check({9'h000, reg_rdata[8], reg_rdata[5:0]}, {9'h000, fl[0], 6'h04});
      else check(reg_rdata, 16'h0000);
      check({15'h0000, irq}, 16'h0000);
    end
    $display("frame and register test done");
    end_of_test();
  end
endmodule
`default_nettype wire
